// File: core/dual_clock_fifo_defines.vh
// Purpose: Constants for the dual-clock FIFO port, flag and mailbox block
// Assumes: Included by bare name from core design files
// Notes:   Definitions only
`ifndef DUAL_CLOCK_FIFO_DEFINES_VH
`define DUAL_CLOCK_FIFO_DEFINES_VH

// Offset programming methods, coded as {hi select, lo select}
`define DCF_MODE_SERIAL   2'h3
`define DCF_MODE_PRESET64 2'h2
`define DCF_MODE_PRESET8  2'h1
`define DCF_MODE_PARALLEL 2'h0

// Preset offset values
`define DCF_PRESET_64     9'h040
`define DCF_PRESET_8      9'h008

// Serial load length in bits
`define DCF_SERIAL_BITS   5'h12

// Port-A edges from end of configuration to run state; input-ready rises on the next edge
`define DCF_IR_DELAY      2'h2

// Offsets loaded over port A in parallel mode
`define DCF_PAR_WORDS     2'h2

// Reset values of the flags
`define DCF_RST_IR        1'b0
`define DCF_RST_OR        1'b0
`define DCF_RST_AE_N      1'b0
`define DCF_RST_AF_N      1'b1
`define DCF_RST_MBF_N     1'b1

`endif

// File: core/dual_clock_fifo_port_mailbox_control.v
// Purpose: Port gating, input-ready, mailboxes and flag offset loading
//          of a two-port 36-bit FIFO, both port clocks sampled by core_clk
// Assumes: Port clocks well below core_clk/4; all pins unsynchronised
// Notes:   Output enables are low while the block drives a data port
//
// What this block does
// - Port-B transfers, output-ready and almost-empty change only on port-B clock rises.
// - Port-A access happens on a port-A clock rise only with chip select low.
// - Port-A data outputs float whenever port-A chip select is high.
// - Port-B access happens on a port-B clock rise only with chip select low.
// - Port-B data outputs float whenever port-B chip select is high.
// - Port-A access needs the port-A master enable high at the edge.
// - Port-B access needs the port-B master enable high at the edge.
// - Flag selects during reset choose preset, parallel or serial offset loading.
// - In serial mode each port-A rise with serial enable low shifts one bit.
// - Serial load is 18 bits, almost-full MSB first, almost-empty LSB last.
// - Input-ready low when full; memory writes ignored while it is low.
// - In retransmit mode writes stop once memory fills up to the marked word.
// - Input-ready held low during reset, raised after reset completes.
// - Port-A mailbox select routes port-A accesses to a mailbox.
// - Port-B mailbox select routes port-B accesses; outputs show mailbox or FIFO data.
// - Port-A edge writing the A-to-B mailbox drives its flag low.
// - Port-B mailbox read returns the A-to-B mailbox flag high.
// - Port-B edge writing the B-to-A mailbox drives its flag low.
// - Port-A mailbox read returns the B-to-A mailbox flag high.
// - Reset drives both mailbox flags high.
// - Port-A write/read select high writes, low reads; outputs float when high.
// - Port-B select low writes, high reads; outputs float when low.
// - Selects at reset rise: 11 serial, 10 preset 64, 01 preset 8, 00 parallel.
`timescale 1ns/1ps
`include "dual_clock_fifo_defines.vh"

module sync_word_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  input  wire             clear,
  // Fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // Drain side
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData,
  // Retransmit control
  input  wire             holdMark,
  input  wire             takeMark,
  input  wire             rewind,
  output wire [AW:0]      level
);
  localparam [AW:0] FULL_COUNT = DEPTH;

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW:0]      wrPtr;
  reg  [AW:0]      rdPtr;
  reg  [AW:0]      markPtr;
  wire [AW:0]      used;

  // Marked words stay protected until retransmit mode ends
  assign used     = wrPtr - (holdMark ? markPtr : rdPtr);
  assign inReady  = (used != FULL_COUNT);
  assign outValid = (wrPtr != rdPtr);
  assign outData  = mem[rdPtr[AW-1:0]];
  assign level    = wrPtr - rdPtr;

  always @(posedge clk) begin
    if (inValid && inReady && !rst && !clear) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always @(posedge clk) begin
    if (rst || clear) begin
      wrPtr   <= {(AW+1){1'b0}};
      rdPtr   <= {(AW+1){1'b0}};
      markPtr <= {(AW+1){1'b0}};
    end else begin
      if (inValid && inReady) begin
        wrPtr <= wrPtr + {{AW{1'b0}}, 1'b1};
      end
      if (takeMark) begin
        markPtr <= rdPtr;
      end
      if (rewind && holdMark) begin
        rdPtr <= markPtr;
      end else if (outValid && outReady) begin
        rdPtr <= rdPtr + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // sync_word_fifo

module dual_clock_fifo_port_mailbox_control #(
  parameter DATA_W  = 36,
  parameter OFS_W   = 9,
  parameter DEPTH   = 32,
  parameter AW      = 5
) (
  // Core clock and reset
  input  wire              core_clk,
  input  wire              sys_rst,
  // Device reset pin
  input  wire              deviceResetN,
  // Port-A control pins
  input  wire              portAClock,
  input  wire              portASelectN,
  input  wire              portAMasterEnable,
  input  wire              portAWriteNotRead,
  input  wire              portAMailboxSelect,
  input  wire              flagSelectHiSerialEnableN,
  input  wire              flagSelectLoSerialBit,
  // Port-A data pins
  input  wire [DATA_W-1:0] portADataIn,
  output reg  [DATA_W-1:0] portADataOut,
  output reg               portADataOeN,
  // Port-A flags
  output reg               inputReady,
  output reg               almostFullN,
  output reg               mailBToAFullN,
  // Port-B control pins
  input  wire              portBClock,
  input  wire              portBSelectN,
  input  wire              portBMasterEnable,
  input  wire              portBReadNotWrite,
  input  wire              portBMailboxSelect,
  input  wire              retransmitMode,
  input  wire              readFromMark,
  // Port-B data pins
  input  wire [DATA_W-1:0] portBDataIn,
  output reg  [DATA_W-1:0] portBDataOut,
  output reg               portBDataOeN,
  // Port-B flags
  output reg               outputReady,
  output reg               almostEmptyN,
  output reg               mailAToBFullN
);
  localparam ST_RESET  = 2'h0;
  localparam ST_SERIAL = 2'h1;
  localparam ST_WAIT   = 2'h2;
  localparam ST_RUN    = 2'h3;
  localparam [AW:0] FULL_COUNT = DEPTH;

  // Two-stage synchronisers for all pins
  reg  [6:0]        aMeta;
  reg  [6:0]        aSync;
  reg               aClkLast;
  reg  [6:0]        bMeta;
  reg  [6:0]        bSync;
  reg               bClkLast;
  reg  [DATA_W-1:0] aDataMeta;
  reg  [DATA_W-1:0] aData;
  reg  [DATA_W-1:0] bDataMeta;
  reg  [DATA_W-1:0] bData;
  reg               rstMeta;
  reg               rstSync;
  reg               rstLast;

  always @(posedge core_clk) begin
    aMeta     <= {portAClock, portASelectN, portAMasterEnable, portAWriteNotRead,
                  portAMailboxSelect, flagSelectHiSerialEnableN, flagSelectLoSerialBit};
    aSync     <= aMeta;
    aClkLast  <= aSync[6];
    bMeta     <= {portBClock, portBSelectN, portBMasterEnable, portBReadNotWrite,
                  portBMailboxSelect, retransmitMode, readFromMark};
    bSync     <= bMeta;
    bClkLast  <= bSync[6];
    aDataMeta <= portADataIn;
    aData     <= aDataMeta;
    bDataMeta <= portBDataIn;
    bData     <= bDataMeta;
    rstMeta   <= deviceResetN;
    rstSync   <= rstMeta;
    rstLast   <= rstSync;
  end

  wire aEdge     = aSync[6] & ~aClkLast;
  wire aSelN     = aSync[5];
  wire aEn       = aSync[4];
  wire aWnr      = aSync[3];
  wire aMb       = aSync[2];
  wire aSerEnN   = aSync[1];
  wire aSerBit   = aSync[0];
  wire bEdge     = bSync[6] & ~bClkLast;
  wire bSelN     = bSync[5];
  wire bEn       = bSync[4];
  wire bRnw      = bSync[3];
  wire bMb       = bSync[2];
  wire bRtm      = bSync[1];
  wire bRfm      = bSync[0];
  wire devRst    = sys_rst | ~rstSync;
  wire rstRise   = rstSync & ~rstLast;

  // Qualified accesses
  wire aAccess   = aEdge & ~aSelN & aEn;
  wire aWrite    = aAccess & aWnr;
  wire aRead     = aAccess & ~aWnr;
  wire bAccess   = bEdge & ~bSelN & bEn;
  wire bWrite    = bAccess & ~bRnw;
  wire bRead     = bAccess & bRnw;

  // Configuration state
  reg  [1:0]       state;
  reg  [1:0]       mode;
  reg  [1:0]       irCount;
  reg  [4:0]       serCount;
  reg  [1:0]       parCount;
  reg  [OFS_W-1:0] fullOffset;
  reg  [OFS_W-1:0] emptyOffset;
  reg              rtActive;
  reg  [DATA_W-1:0] mailboxAToB;
  reg  [DATA_W-1:0] mailboxBToA;

  wire             fifoInReady;
  wire             fifoOutValid;
  wire [DATA_W-1:0] fifoOut;
  wire [AW:0]      fifoLevel;
  wire             parLoading = (mode == `DCF_MODE_PARALLEL) && (parCount != `DCF_PAR_WORDS);
  wire             fifoPush   = aWrite & ~aMb & inputReady & ~parLoading & (state == ST_RUN);
  wire             fifoPop    = bRead & ~bMb & outputReady & ~(bRfm & rtActive);
  wire             takeMark   = bEdge & bRtm & ~rtActive & outputReady;
  wire             rewind     = bEdge & bRfm;

  sync_word_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clk      (core_clk),
    .rst      (sys_rst),
    .clear    (~rstSync),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .inData   (aData),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOut),
    .holdMark (rtActive),
    .takeMark (takeMark),
    .rewind   (rewind),
    .level    (fifoLevel)
  );

  // Offset programming and input-ready sequencing on port A
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state       <= ST_RESET;
      mode        <= `DCF_MODE_PARALLEL;
      irCount     <= 2'h0;
      serCount    <= 5'h00;
      parCount    <= 2'h0;
      fullOffset  <= `DCF_PRESET_8;
      emptyOffset <= `DCF_PRESET_8;
    end else if (!rstSync) begin
      state    <= ST_RESET;
      irCount  <= 2'h0;
      serCount <= 5'h00;
      parCount <= 2'h0;
    end else begin
      case (state)
        ST_RESET: begin
          if (rstRise) begin
            mode <= {aSerEnN, aSerBit};
            if ({aSerEnN, aSerBit} == `DCF_MODE_SERIAL) begin
              state <= ST_SERIAL;
            end else begin
              state <= ST_WAIT;
              if ({aSerEnN, aSerBit} == `DCF_MODE_PRESET64) begin
                fullOffset  <= `DCF_PRESET_64;
                emptyOffset <= `DCF_PRESET_64;
              end else if ({aSerEnN, aSerBit} == `DCF_MODE_PRESET8) begin
                fullOffset  <= `DCF_PRESET_8;
                emptyOffset <= `DCF_PRESET_8;
              end
            end
          end
        end
        ST_SERIAL: begin
          if (aEdge && !aSerEnN) begin
            {fullOffset, emptyOffset} <= {fullOffset[OFS_W-2:0], emptyOffset, aSerBit};
            serCount <= serCount + 5'h01;
            if (serCount == `DCF_SERIAL_BITS - 5'h01) begin
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (aEdge) begin
            irCount <= irCount + 2'h1;
            if (irCount == `DCF_IR_DELAY - 2'h1) begin
              state <= ST_RUN;
            end
          end
        end
        default: begin
          if (aWrite && !aMb && parLoading && inputReady) begin
            parCount <= parCount + 2'h1;
            if (parCount == 2'h0) begin
              fullOffset <= aData[OFS_W-1:0];
            end else begin
              emptyOffset <= aData[OFS_W-1:0];
            end
          end
        end
      endcase
    end
  end

  // Port-A flags, updated on port-A clock rises
  always @(posedge core_clk) begin
    if (devRst) begin
      inputReady  <= `DCF_RST_IR;
      almostFullN <= `DCF_RST_AF_N;
    end else if (aEdge) begin
      // Full, or filled up to the retransmit mark, drops input-ready
      inputReady  <= (state == ST_RUN) & (fifoInReady | parLoading);
      almostFullN <= ({{(OFS_W-AW-1){1'b0}}, FULL_COUNT - fifoLevel} > fullOffset);
    end
  end

  // Port-B flags and retransmit mode, updated on port-B clock rises
  always @(posedge core_clk) begin
    if (devRst) begin
      outputReady  <= `DCF_RST_OR;
      almostEmptyN <= `DCF_RST_AE_N;
      rtActive     <= 1'b0;
    end else if (bEdge) begin
      outputReady  <= fifoOutValid;
      almostEmptyN <= ({{(OFS_W-AW-1){1'b0}}, fifoLevel} > emptyOffset);
      if (takeMark) begin
        rtActive <= 1'b1;
      end else if (!bRtm) begin
        rtActive <= 1'b0;
      end
    end
  end

  // Mailboxes; a new write beats a simultaneous read-out
  always @(posedge core_clk) begin
    if (devRst) begin
      mailAToBFullN <= `DCF_RST_MBF_N;
      mailBToAFullN <= `DCF_RST_MBF_N;
      mailboxAToB   <= {DATA_W{1'b0}};
      mailboxBToA   <= {DATA_W{1'b0}};
    end else begin
      if (aWrite && aMb) begin
        mailboxAToB   <= aData;
        mailAToBFullN <= 1'b0;
      end else if (bRead && bMb) begin
        mailAToBFullN <= 1'b1;
      end
      if (bWrite && bMb) begin
        mailboxBToA   <= bData;
        mailBToAFullN <= 1'b0;
      end else if (aRead && aMb) begin
        mailBToAFullN <= 1'b1;
      end
    end
  end

  // Data output drivers
  always @(posedge core_clk) begin
    if (sys_rst) begin
      portADataOut <= {DATA_W{1'b0}};
      portADataOeN <= 1'b1;
      portBDataOut <= {DATA_W{1'b0}};
      portBDataOeN <= 1'b1;
    end else begin
      portADataOut <= mailboxBToA;
      portADataOeN <= aSelN | aWnr;
      portBDataOut <= bMb ? mailboxAToB : fifoOut;
      portBDataOeN <= bSelN | ~bRnw;
    end
  end
endmodule // dual_clock_fifo_port_mailbox_control

// File: tb/port_clock_source.sv
// Purpose: Far-side port clocks for both FIFO ports
// Assumes: Both clocks free-running, unrelated in phase to core_clk
// Notes:   Period 64 ns each, offsets keep edges off core edges
`timescale 1ns/1ps
module port_clock_source (
  // Port clocks
  output logic port_a_clock,
  output logic port_b_clock
);
  initial begin
    port_a_clock = 1'b0;
    #3;
    forever #32 port_a_clock = ~port_a_clock;
  end
  initial begin
    port_b_clock = 1'b0;
    #17;
    forever #32 port_b_clock = ~port_b_clock;
  end
endmodule // port_clock_source

// File: tb/dual_clock_fifo_port_mailbox_control_properties.sv
// Purpose: Port timing checks of the FIFO port and mailbox block
// Assumes: Port clocks sampled by core_clk, pins unsynchronised
// Notes:   Ages count core cycles since a port clock pin rise
`timescale 1ns/1ps
module dual_clock_fifo_port_mailbox_control_properties (
  // Clock and resets
  input logic core_clk,
  input logic sys_rst,
  input logic deviceResetN,
  // Port pins
  input logic portAClock,
  input logic portBClock,
  input logic portASelectN,
  input logic portBSelectN,
  input logic portAWriteNotRead,
  input logic portBReadNotWrite,
  // Watched outputs
  input logic portADataOeN,
  input logic portBDataOeN,
  input logic inputReady,
  input logic outputReady,
  input logic almostEmptyN,
  input logic mailAToBFullN,
  input logic mailBToAFullN
);
  logic       prevA;
  logic       prevB;
  logic [3:0] aAge;
  logic [3:0] bAge;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  always @(posedge core_clk) begin
    prevA <= portAClock;
    prevB <= portBClock;
    if (sys_rst) begin
      aAge <= 4'hf;
      bAge <= 4'hf;
    end else begin
      if (portAClock && !prevA) aAge <= 4'h0;
      else if (aAge != 4'hf) aAge <= aAge + 4'h1;
      if (portBClock && !prevB) bAge <= 4'h0;
      else if (bAge != 4'hf) bAge <= bAge + 4'h1;
    end
  end
  a_a_float_sel: assert property (portASelectN [*5] |-> portADataOeN)
    else $error("port A driven with select high");
  a_b_float_sel: assert property (portBSelectN [*5] |-> portBDataOeN)
    else $error("port B driven with select high");
  a_a_float_write: assert property (portAWriteNotRead [*5] |-> portADataOeN)
    else $error("port A driven during write");
  a_b_float_write: assert property (!portBReadNotWrite [*5] |-> portBDataOeN)
    else $error("port B driven during write");
  a_ir_reset_low: assert property (!deviceResetN [*6] |-> !inputReady)
    else $error("input ready high in reset");
  a_mail_reset_empty: assert property (!deviceResetN [*6] |-> mailAToBFullN && mailBToAFullN)
    else $error("mailbox flag low in reset");
  a_or_b_edge: assert property ($changed(outputReady) && deviceResetN && $past(deviceResetN, 6) |-> bAge <= 6)
    else $error("output ready moved off a B edge");
  a_ae_b_edge: assert property ($changed(almostEmptyN) && deviceResetN && $past(deviceResetN, 6) |-> bAge <= 6)
    else $error("almost empty moved off a B edge");
  a_mailbox_a_to_b_set: assert property ($fell(mailAToBFullN) |-> aAge <= 6)
    else $error("A-to-B flag fell off an A edge");
  a_mailbox_a_to_b_clear: assert property ($rose(mailAToBFullN) && deviceResetN && $past(deviceResetN, 6) |-> bAge <= 6)
    else $error("A-to-B flag rose off a B edge");
  a_mailbox_b_to_a_set: assert property ($fell(mailBToAFullN) |-> bAge <= 6)
    else $error("B-to-A flag fell off a B edge");
  a_mailbox_b_to_a_clear: assert property ($rose(mailBToAFullN) && deviceResetN && $past(deviceResetN, 6) |-> aAge <= 6)
    else $error("B-to-A flag rose off an A edge");
endmodule // dual_clock_fifo_port_mailbox_control_properties

bind dual_clock_fifo_port_mailbox_control dual_clock_fifo_port_mailbox_control_properties u_props (
  .core_clk, .sys_rst, .deviceResetN, .portAClock, .portBClock, .portASelectN, .portBSelectN,
  .portAWriteNotRead, .portBReadNotWrite, .portADataOeN, .portBDataOeN, .inputReady,
  .outputReady, .almostEmptyN, .mailAToBFullN, .mailBToAFullN
);

// File: tb/dual_clock_fifo_port_mailbox_control_tb.sv
// Purpose: Self-checking bench for FIFO ports, mailboxes and offsets
// Assumes: Inputs change on core_clk falling edges
// Notes:   Retransmit exercised once after the mailbox checks
`timescale 1ns/1ps
module dual_clock_fifo_port_mailbox_control_tb;
  logic core_clk = 1'b0, sys_rst = 1'b1, deviceResetN = 1'b0, portAClock, portBClock;
  logic portASelectN = 1'b1, portAMasterEnable = 1'b0, portAWriteNotRead = 1'b1, portAMailboxSelect = 1'b0;
  logic flagSelectHiSerialEnableN = 1'b1, flagSelectLoSerialBit = 1'b1;
  logic portBSelectN = 1'b1, portBMasterEnable = 1'b0, portBReadNotWrite = 1'b1, portBMailboxSelect = 1'b0;
  logic retransmitMode = 1'b0, readFromMark = 1'b0;
  logic [35:0] portADataIn = 36'h0, portBDataIn = 36'h0, portADataOut, portBDataOut, w, q;
  logic portADataOeN, portBDataOeN, inputReady, almostFullN, mailBToAFullN;
  logic outputReady, almostEmptyN, mailAToBFullN, oeA, oeB;
  logic [15:0] seed = 16'hedca;
  logic [35:0] expQ[$];
  localparam logic [17:0] serialBits = {9'h01f, 9'h002};
  int fail_count = 0, n_compared = 0, i, m;
  always #4 core_clk = ~core_clk;
  port_clock_source u_clk (.port_a_clock(portAClock), .port_b_clock(portBClock));
  dual_clock_fifo_port_mailbox_control dut (
    .core_clk, .sys_rst, .deviceResetN, .portAClock, .portASelectN, .portAMasterEnable,
    .portAWriteNotRead, .portAMailboxSelect, .flagSelectHiSerialEnableN, .flagSelectLoSerialBit,
    .portADataIn, .portADataOut, .portADataOeN, .inputReady, .almostFullN, .mailBToAFullN,
    .portBClock, .portBSelectN, .portBMasterEnable, .portBReadNotWrite, .portBMailboxSelect,
    .retransmitMode, .readFromMark, .portBDataIn, .portBDataOut, .portBDataOeN,
    .outputReady, .almostEmptyN, .mailAToBFullN
  );
  function automatic logic [35:0] nextWord();
    for (int k = 0; k < 16; k++) seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {seed[3:0], seed, ~seed};
  endfunction
  // Preset 64 exceeds 32 free words, preset 8 does not
  function automatic logic expAf(int mode);
    return mode != 2;
  endfunction
  function automatic logic pick(int k);
    return k == 0 ? inputReady : k == 1 ? outputReady : almostFullN;
  endfunction
  task test_done();
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic got, input logic want);
    n_compared++;
    if (got !== want) begin
      fail_count++;
      $display("mismatch %0t flag %b want %b", $time, got, want);
    end
  endtask
  task chkW(input logic [35:0] got, input logic [35:0] want);
    n_compared++;
    if (got !== want) begin
      fail_count++;
      $display("mismatch %0t word %h want %h", $time, got, want);
    end
  endtask
  task waitFor(input int k, input logic v);
    for (int j = 0; j < 300 && pick(k) !== v; j++) @(negedge core_clk);
    n_compared++;
    if (pick(k) !== v) begin
      fail_count++;
      $display("mismatch %0t wait %0d timed out", $time, k);
      test_done();
    end
  endtask
  task portA(input logic s, e, wr, mb, input logic [35:0] d, output logic [35:0] r);
    @(negedge portAClock);
    @(negedge core_clk);
    {portASelectN, portAMasterEnable, portAWriteNotRead, portAMailboxSelect} = {s, e, wr, mb};
    portADataIn = d;
    @(posedge portAClock);
    r = portADataOut;
    oeA = portADataOeN;
    @(negedge portAClock);
    @(negedge core_clk);
    portASelectN = 1'b1;
    portAMasterEnable = 1'b0;
  endtask
  task portB(input logic s, e, rd, mb, input logic [35:0] d, output logic [35:0] r);
    @(negedge portBClock);
    @(negedge core_clk);
    {portBSelectN, portBMasterEnable, portBReadNotWrite, portBMailboxSelect} = {s, e, rd, mb};
    portBDataIn = d;
    @(posedge portBClock);
    r = portBDataOut;
    oeB = portBDataOeN;
    @(negedge portBClock);
    @(negedge core_clk);
    portBSelectN = 1'b1;
    portBMasterEnable = 1'b0;
  endtask
  task devReset(input logic [1:0] mode);
    @(negedge core_clk);
    deviceResetN = 1'b0;
    {flagSelectHiSerialEnableN, flagSelectLoSerialBit} = mode;
    repeat (6) @(posedge portBClock);
    chk(inputReady, 1'b0);
    chk(mailAToBFullN & mailBToAFullN, 1'b1);
    @(negedge core_clk);
    deviceResetN = 1'b1;
    repeat (6) @(negedge core_clk);
    flagSelectHiSerialEnableN = 1'b1;
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    devReset(2'h3);
    for (i = 17; i >= 0; i--) begin
      @(negedge portAClock);
      @(negedge core_clk);
      flagSelectHiSerialEnableN = 1'b0;
      flagSelectLoSerialBit = serialBits[i];
      @(negedge portAClock);
      @(negedge core_clk);
      flagSelectHiSerialEnableN = 1'b1;
    end
    waitFor(0, 1'b1);
    chk(almostFullN, 1'b1);
    for (i = 0; i < 33; i++) begin
      w = nextWord();
      portA(1'b0, 1'b1, 1'b1, 1'b0, w, q);
      if (i < 32) expQ.push_back(w);
      if (i == 0) waitFor(2, 1'b0);
    end
    chk(inputReady, 1'b0);
    waitFor(1, 1'b1);
    for (i = 0; i < 32; i++) begin
      portB(1'b0, 1'b1, 1'b1, 1'b0, 36'h0, q);
      chkW(q, expQ.pop_front());
      chk(oeB, 1'b0);
    end
    waitFor(1, 1'b0);
    waitFor(0, 1'b1);
    w = nextWord();
    portA(1'b1, 1'b1, 1'b1, 1'b1, w, q);
    portA(1'b0, 1'b0, 1'b1, 1'b1, w, q);
    chk(mailAToBFullN, 1'b1);
    portA(1'b0, 1'b1, 1'b1, 1'b1, w, q);
    chk(mailAToBFullN, 1'b0);
    chk(oeA, 1'b1);
    chk(outputReady, 1'b0);
    portB(1'b0, 1'b1, 1'b1, 1'b1, 36'h0, q);
    chkW(q, w);
    chk(oeB, 1'b0);
    chk(mailAToBFullN, 1'b1);
    w = nextWord();
    portB(1'b0, 1'b0, 1'b0, 1'b1, w, q);
    portB(1'b1, 1'b1, 1'b0, 1'b1, w, q);
    chk(mailBToAFullN, 1'b1);
    portB(1'b0, 1'b1, 1'b0, 1'b1, w, q);
    chk(mailBToAFullN, 1'b0);
    chk(oeB, 1'b1);
    portA(1'b0, 1'b1, 1'b0, 1'b1, 36'h0, q);
    chkW(q, w);
    chk(oeA, 1'b0);
    chk(mailBToAFullN, 1'b1);
    portA(1'b0, 1'b1, 1'b1, 1'b1, w, q);
    // Mark the head, read three, then fill up to the mark
    retransmitMode = 1'b1;
    for (i = 0; i < 32; i++) begin
      w = nextWord();
      portA(1'b0, 1'b1, 1'b1, 1'b0, w, q);
      expQ.push_back(w);
      if (i == 2) begin
        waitFor(1, 1'b1);
        repeat (2) @(posedge portBClock);
        chk(almostEmptyN, 1'b1);
        for (m = 0; m < 3; m++) begin
          portB(1'b0, 1'b1, 1'b1, 1'b0, 36'h0, q);
          chkW(q, expQ[m]);
          if (m == 0) begin
            repeat (2) @(posedge portBClock);
            chk(almostEmptyN, 1'b0);
          end
        end
      end
    end
    waitFor(0, 1'b0);
    @(negedge portBClock);
    @(negedge core_clk);
    readFromMark = 1'b1;
    @(negedge portBClock);
    @(negedge core_clk);
    readFromMark = 1'b0;
    for (i = 0; i < 32; i++) begin
      portB(1'b0, 1'b1, 1'b1, 1'b0, 36'h0, q);
      chkW(q, expQ.pop_front());
    end
    retransmitMode = 1'b0;
    waitFor(0, 1'b1);
    for (m = 2; m >= 0; m--) begin
      devReset(m[1:0]);
      waitFor(0, 1'b1);
      repeat (4) @(posedge portAClock);
      if (m != 0) chk(almostFullN, expAf(m));
    end
    // Parallel mode: two offset writes, then one data word
    portA(1'b0, 1'b1, 1'b1, 1'b0, 36'h000000020, q);
    portA(1'b0, 1'b1, 1'b1, 1'b0, 36'h000000000, q);
    w = nextWord();
    portA(1'b0, 1'b1, 1'b1, 1'b0, w, q);
    waitFor(1, 1'b1);
    chk(almostFullN, 1'b0);
    chk(almostEmptyN, 1'b1);
    portB(1'b0, 1'b1, 1'b1, 1'b0, 36'h0, q);
    chkW(q, w);
    test_done();
  end
endmodule // dual_clock_fifo_port_mailbox_control_tb
